/* tsg_defines.svh */
// Offsets, field positions, reset values and timing counts of the
// transmit symbol generator. Assumes inclusion by bare name.
`ifndef TSG_DEFINES_SVH
`define TSG_DEFINES_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define TSG_IDX_SYM0_H      8'h4D
`define TSG_IDX_SYM0_L      8'h4E
`define TSG_IDX_SYM1_H      8'h4F
`define TSG_IDX_SYM1_L      8'h50
`define TSG_IDX_SYM2        8'h51
`define TSG_IDX_SYM3        8'h52
`define TSG_IDX_SYM10_LEN   8'h53
`define TSG_IDX_SYM32_LEN   8'h54
`define TSG_IDX_BURST_CTRL  8'h55
`define TSG_IDX_MOD         8'h56
`define TSG_IDX_BURST_LEN   8'h60
`define TSG_IDX_SC_RATE     8'h61
`define TSG_IDX_CONTROL     8'h62
`define TSG_IDX_STATUS      8'h63

// ************************************************************
// Writable bit masks (reserved bits read zero)
// ************************************************************
`define TSG_MASK_SYM32_LEN  8'h77
`define TSG_MASK_BURST_CTRL 8'h77
`define TSG_MASK_MOD        8'h7F
`define TSG_MASK_SC_RATE    8'h08
`define TSG_RESET_VALUE     8'h00

// ************************************************************
// Field positions
// ************************************************************
`define TSG_BIT_S1_LEVEL    6
`define TSG_BIT_S1_ALONE    5
`define TSG_BIT_S1_ON       4
`define TSG_BIT_S0_LEVEL    2
`define TSG_BIT_S0_ALONE    1
`define TSG_BIT_S0_ON       0
`define TSG_BIT_MILLER      6
`define TSG_BIT_INVERT      3
`define TSG_BIT_SC_RATE     3
`define TSG_BIT_START       7

// ************************************************************
// Timing
// ************************************************************
`define TSG_CLK_HZ          25000000
`define TSG_SC_LOW_HZ       424000
`define TSG_SC_HIGH_HZ      848000
`define TSG_SC_LOW_HALF     (`TSG_CLK_HZ / (2 * `TSG_SC_LOW_HZ))
`define TSG_SC_HIGH_HALF    (`TSG_CLK_HZ / (2 * `TSG_SC_HIGH_HZ))
`define TSG_BIT_CLKS        16

`endif

/* tsg_pkg.sv */
// Types shared by the transmit symbol generator.
// Assumes tsg_defines.svh is not needed here; types only.
package tsg_pkg;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tsg_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tsg_apb_rsp_t;

   // Sequencer states
   typedef enum logic [1:0] {
      TSG_IDLE    = 2'b00,
      TSG_BURST   = 2'b01,
      TSG_PATTERN = 2'b10
   } tsg_state_t;

   // Envelope codes
   typedef enum logic [2:0] {
      TSG_ENV_DIRECT  = 3'b000,
      TSG_ENV_MANCH   = 3'b001,
      TSG_ENV_MANCH_SC= 3'b010,
      TSG_ENV_BPSK    = 3'b011,
      TSG_ENV_RZ_LATE = 3'b100,
      TSG_ENV_RZ_EARLY= 3'b101
   } tsg_env_t;

endpackage : tsg_pkg

/* tsg_symbol_gen.sv */
// Transmit symbol generator: APB register file and symbol sequencer.
// Assumes an APB master on ref_clk and an RF driver taking tx_data.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "tsg_defines.svh"

// Summary of operation
// - Third symbol pattern is full byte
// - Fourth symbol pattern is full byte
// - Upper nibble: second symbol bits minus one
// - Lower nibble: first symbol bits minus one
// - Fourth symbol length, three bits, minus one
// - Third symbol length, three low bits
// - Second symbol burst level select
// - Second symbol burst alone, no pattern
// - Second symbol burst enable, separate length
// - First symbol burst level select
// - First symbol burst alone, no pattern
// - First symbol burst enable, separate length
// - Miller enable applies modified Miller pulses
// - Pulse kind: none, start, half, three-quarter
// - Invert bit inverts low pair output
// - Envelope codes 0h to 5h; 6h,7h reserved
// - Low pair output combines pseudo stream with envelope
// - Envelope 5h: early half-bit pulse
// - Low pair patterns are sixteen bits
// - Subcarrier rate 424 or 848 kHz
module tsg_symbol_gen #(
   parameter int BIT_CLKS = `TSG_BIT_CLKS     // Clocks per symbol bit
) (
   input  wire logic                  ref_clk, // 25 MHz clock
   input  wire logic                  srst,    // Synchronous reset
   input  wire tsg_pkg::tsg_apb_req_t apb_req, // APB request
   output tsg_pkg::tsg_apb_rsp_t      apb_rsp, // APB answer
   output logic                       tx_data, // Modulated bit stream
   output logic                       tx_active // Symbol in progress
);
   import tsg_pkg::*;

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (BIT_CLKS < 4 || (BIT_CLKS % 4) != 0 || BIT_CLKS > 1024)
   begin : g_bad_bit_clks
      $error("BIT_CLKS must be a multiple of four, 4 to 1024");
   end
   localparam int QUARTER  = BIT_CLKS / 4;
   localparam int SC_LOW   = `TSG_SC_LOW_HALF;
   localparam int SC_HIGH  = `TSG_SC_HIGH_HALF;
   // ************************************************************
   // Registers
   // ************************************************************
   logic [15:0] first_symbol_pattern;
   logic [15:0] second_symbol_pattern;
   logic [7:0]  third_symbol_pattern;
   logic [7:0]  fourth_symbol_pattern;
   logic [7:0]  symbol10_length;
   logic [7:0]  symbol32_length;
   logic [7:0]  symbol10_burst_control;
   logic [7:0]  symbol10_modulation;
   logic [7:0]  low_pair_burst_length;
   logic [7:0]  sc_rate_reg;
   logic [7:0]  idx;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [7:0]  wbyte;
   logic [31:0] next_rdata;
   logic        next_err;
   tsg_state_t  state;
   logic [1:0]  cur_sym;
   logic [10:0] phase;
   logic [7:0]  bit_left;
   logic [3:0]  bit_pos;
   logic        prev_bit;
   logic        sc;
   logic [5:0]  sc_cnt;
   logic        start_req;
   logic [1:0]  start_sym;
   // Field aliases
   logic [3:0]  first_symbol_bit_count;
   logic [3:0]  second_symbol_bit_count;
   logic [2:0]  third_symbol_bit_count;
   logic [2:0]  fourth_symbol_bit_count;
   logic        low_pair_miller_on;
   logic [1:0]  low_pair_pulse_kind;
   logic        low_pair_invert;
   logic [2:0]  low_pair_envelope;
   logic        low_pair_subcarrier_rate;

   assign second_symbol_bit_count  = symbol10_length[7:4];
   assign first_symbol_bit_count   = symbol10_length[3:0];
   assign fourth_symbol_bit_count  = symbol32_length[6:4];
   assign third_symbol_bit_count   = symbol32_length[2:0];
   assign low_pair_miller_on       = symbol10_modulation[`TSG_BIT_MILLER];
   assign low_pair_pulse_kind      = symbol10_modulation[5:4];
   assign low_pair_invert          = symbol10_modulation[`TSG_BIT_INVERT];
   assign low_pair_envelope        = symbol10_modulation[2:0];
   assign low_pair_subcarrier_rate = sc_rate_reg[`TSG_BIT_SC_RATE];
   // ************************************************************
   // APB decode
   // ************************************************************
   // Index from word address; low address bits must be zero
   assign idx   = apb_req.paddr[9:2];
   assign wbyte = apb_req.pwdata[7:0];
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & addr_ok;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

   // Register file write; reserved bits masked on write
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         first_symbol_pattern   <= {2{`TSG_RESET_VALUE}};
         second_symbol_pattern  <= {2{`TSG_RESET_VALUE}};
         third_symbol_pattern   <= `TSG_RESET_VALUE;
         fourth_symbol_pattern  <= `TSG_RESET_VALUE;
         symbol10_length        <= `TSG_RESET_VALUE;
         symbol32_length        <= `TSG_RESET_VALUE;
         symbol10_burst_control <= `TSG_RESET_VALUE;
         symbol10_modulation    <= `TSG_RESET_VALUE;
         low_pair_burst_length  <= `TSG_RESET_VALUE;
         sc_rate_reg            <= `TSG_RESET_VALUE;
      end
      else if (wr_en)
      begin
         if (idx == `TSG_IDX_SYM0_H) first_symbol_pattern[15:8] <= wbyte;
         else if (idx == `TSG_IDX_SYM0_L) first_symbol_pattern[7:0] <= wbyte;
         else if (idx == `TSG_IDX_SYM1_H) second_symbol_pattern[15:8] <= wbyte;
         else if (idx == `TSG_IDX_SYM1_L) second_symbol_pattern[7:0] <= wbyte;
         else if (idx == `TSG_IDX_SYM2) third_symbol_pattern <= wbyte;
         else if (idx == `TSG_IDX_SYM3) fourth_symbol_pattern <= wbyte;
         else if (idx == `TSG_IDX_SYM10_LEN) symbol10_length <= wbyte;
         else if (idx == `TSG_IDX_SYM32_LEN)
            symbol32_length <= wbyte & `TSG_MASK_SYM32_LEN;
         else if (idx == `TSG_IDX_BURST_CTRL)
            symbol10_burst_control <= wbyte & `TSG_MASK_BURST_CTRL;
         else if (idx == `TSG_IDX_MOD)
            symbol10_modulation <= wbyte & `TSG_MASK_MOD;
         else if (idx == `TSG_IDX_BURST_LEN) low_pair_burst_length <= wbyte;
         else if (idx == `TSG_IDX_SC_RATE)
            sc_rate_reg <= wbyte & `TSG_MASK_SC_RATE;
      end
   end
   // Start request from control register write
   assign start_req = wr_en && (idx == `TSG_IDX_CONTROL) && wbyte[`TSG_BIT_START];
   assign start_sym = wbyte[1:0];

   // Read mux and address check
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      addr_ok    = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
      if (idx == `TSG_IDX_SYM0_H) next_rdata[7:0] = first_symbol_pattern[15:8];
      else if (idx == `TSG_IDX_SYM0_L) next_rdata[7:0] = first_symbol_pattern[7:0];
      else if (idx == `TSG_IDX_SYM1_H) next_rdata[7:0] = second_symbol_pattern[15:8];
      else if (idx == `TSG_IDX_SYM1_L) next_rdata[7:0] = second_symbol_pattern[7:0];
      else if (idx == `TSG_IDX_SYM2) next_rdata[7:0] = third_symbol_pattern;
      else if (idx == `TSG_IDX_SYM3) next_rdata[7:0] = fourth_symbol_pattern;
      else if (idx == `TSG_IDX_SYM10_LEN) next_rdata[7:0] = symbol10_length;
      else if (idx == `TSG_IDX_SYM32_LEN) next_rdata[7:0] = symbol32_length;
      else if (idx == `TSG_IDX_BURST_CTRL) next_rdata[7:0] = symbol10_burst_control;
      else if (idx == `TSG_IDX_MOD) next_rdata[7:0] = symbol10_modulation;
      else if (idx == `TSG_IDX_BURST_LEN) next_rdata[7:0] = low_pair_burst_length;
      else if (idx == `TSG_IDX_SC_RATE) next_rdata[7:0] = sc_rate_reg;
      else if (idx == `TSG_IDX_CONTROL) next_rdata[7:0] = 8'h00;
      else if (idx == `TSG_IDX_STATUS)
         next_rdata[7:0] = {5'h00, cur_sym, (state != TSG_IDLE)};
      else addr_ok = 1'b0;
   end
   // Status is read-only
   assign next_err = apb_req.psel & apb_req.penable &
                     (~addr_ok | (apb_req.pwrite & (idx == `TSG_IDX_STATUS)));

   // Zero-wait answer
   always_comb
   begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = next_err;
      apb_rsp.prdata  = (rd_en && addr_ok) ? next_rdata : 32'h0000_0000;
   end

   // ************************************************************
   // Helper functions
   // ************************************************************
   // True while phase lies in the given bit quarter
   function automatic logic in_quarter(input logic [10:0] ph, input logic [1:0] q);
      logic [10:0] lo;
      lo = 11'(QUARTER) * 11'(q);
      return (ph >= lo) && (ph < lo + 11'(QUARTER));
   endfunction

   // Pulse window for a pulse kind
   function automatic logic pulse_at(input logic [10:0] ph, input logic [1:0] kind);
      logic r;
      r = 1'b0;
      case (kind)
         2'h1: r = in_quarter(ph, 2'h0);
         2'h2: r = in_quarter(ph, 2'h2);
         2'h3: r = in_quarter(ph, 2'h3);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ************************************************************
   // Subcarrier
   // ************************************************************
   // Free-running subcarrier at the selected rate
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         sc_cnt <= 6'h00;
         sc     <= 1'b0;
      end
      else if (sc_cnt >= 6'(low_pair_subcarrier_rate ? SC_HIGH - 1 : SC_LOW - 1))
      begin
         sc_cnt <= 6'h00;
         sc     <= ~sc;
      end
      else sc_cnt <= sc_cnt + 6'h01;
   end
   // ************************************************************
   // Sequencer
   // ************************************************************
   logic        last_phase;
   logic        has_burst;
   logic        burst_alone;
   logic        burst_level;
   logic [3:0]  top_bit;
   logic [15:0] cur_pattern;
   logic        pattern_bit;
   logic        pseudo_bit;
   assign last_phase = (phase == 11'(BIT_CLKS - 1));
   // Per-symbol burst and pattern selection
   always_comb
   begin
      has_burst   = 1'b0;
      burst_alone = 1'b0;
      burst_level = 1'b0;
      top_bit     = 4'h0;
      cur_pattern = 16'h0000;
      case (cur_sym)
         2'h0:
         begin
            has_burst   = symbol10_burst_control[`TSG_BIT_S0_ON];
            burst_alone = symbol10_burst_control[`TSG_BIT_S0_ALONE];
            burst_level = symbol10_burst_control[`TSG_BIT_S0_LEVEL];
            top_bit     = first_symbol_bit_count;
            cur_pattern = first_symbol_pattern;
         end
         2'h1:
         begin
            has_burst   = symbol10_burst_control[`TSG_BIT_S1_ON];
            burst_alone = symbol10_burst_control[`TSG_BIT_S1_ALONE];
            burst_level = symbol10_burst_control[`TSG_BIT_S1_LEVEL];
            top_bit     = second_symbol_bit_count;
            cur_pattern = second_symbol_pattern;
         end
         2'h2:
         begin
            top_bit     = {1'b0, third_symbol_bit_count};
            cur_pattern = {8'h00, third_symbol_pattern};
         end
         default:
         begin
            top_bit     = {1'b0, fourth_symbol_bit_count};
            cur_pattern = {8'h00, fourth_symbol_pattern};
         end
      endcase
   end

   assign pattern_bit = cur_pattern[bit_pos];
   assign pseudo_bit  = (state == TSG_BURST) ? burst_level : pattern_bit;
   // Burst then pattern bits, most significant valid bit first
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state    <= TSG_IDLE;
         cur_sym  <= 2'h0;
         phase    <= 11'h000;
         bit_left <= 8'h00;
         bit_pos  <= 4'h0;
         prev_bit <= 1'b0;
      end
      else
      begin
         case (state)
            TSG_IDLE:
            begin
               phase    <= 11'h000;
               prev_bit <= 1'b0;
               if (start_req)
               begin
                  cur_sym <= start_sym;
                  state   <= TSG_BURST;
                  bit_left <= 8'h00;
               end
            end
            TSG_BURST:
            begin
               // Entry cycle loads the burst count, then counts bits down
               if (bit_left == 8'h00 && phase == 11'h000 && has_burst &&
                   low_pair_burst_length != 8'h00 && !tx_active)
                  bit_left <= low_pair_burst_length;
               else if (bit_left == 8'h00)
               begin
                  phase   <= 11'h000;
                  bit_pos <= top_bit;
                  state   <= burst_alone ? TSG_IDLE : TSG_PATTERN;
               end
               else if (last_phase)
               begin
                  phase    <= 11'h000;
                  prev_bit <= burst_level;
                  bit_left <= bit_left - 8'h01;
               end
               else phase <= phase + 11'h001;
            end
            TSG_PATTERN:
            begin
               if (last_phase)
               begin
                  phase    <= 11'h000;
                  prev_bit <= pattern_bit;
                  if (bit_pos == 4'h0) state <= TSG_IDLE;
                  else bit_pos <= bit_pos - 4'h1;
               end
               else phase <= phase + 11'h001;
            end
            default: state <= TSG_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Modulation
   // ************************************************************
   logic low_pair;
   logic first_half;
   logic coded;
   logic enveloped;
   logic next_tx;
   logic bit_live;

   assign low_pair   = ~cur_sym[1];
   assign first_half = (phase < 11'(2 * QUARTER));
   assign bit_live   = (state == TSG_PATTERN) ||
                       (state == TSG_BURST && bit_left != 8'h00);

   // Pulse, Miller, envelope and inversion for symbols 0 and 1
   always_comb
   begin
      coded = pseudo_bit;
      if (low_pair_miller_on)
      begin
         if (pseudo_bit) coded = in_quarter(phase, 2'h2);
         else coded = prev_bit ? 1'b0 : in_quarter(phase, 2'h0);
      end
      else if (low_pair_pulse_kind != 2'h0)
         coded = pseudo_bit & pulse_at(phase, low_pair_pulse_kind);
      case (low_pair_envelope)
         TSG_ENV_DIRECT:   enveloped = coded;
         TSG_ENV_MANCH:    enveloped = coded ^ ~first_half;
         TSG_ENV_MANCH_SC: enveloped = (coded ^ ~first_half) & sc;
         TSG_ENV_BPSK:     enveloped = coded ^ sc;
         TSG_ENV_RZ_LATE:  enveloped = coded & ~first_half;
         TSG_ENV_RZ_EARLY: enveloped = coded & first_half;
         default:          enveloped = 1'b0;
      endcase
      if (!bit_live) next_tx = 1'b0;
      else if (low_pair) next_tx = enveloped ^ low_pair_invert;
      else next_tx = pseudo_bit;
   end
   // Registered output stream
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         tx_data   <= 1'b0;
         tx_active <= 1'b0;
      end
      else
      begin
         tx_data   <= next_tx;
         tx_active <= bit_live;
      end
   end

endmodule // tsg_symbol_gen

/* tsg_props.sv */
// Port checker of the transmit symbol generator.
// Assumes it is bound to every tsg_symbol_gen instance.
`timescale 1ns/1ns
module tsg_props #(
   parameter int BIT_CLKS = 16 // Clocks per bit
) (
   input wire logic                  ref_clk,  // Clock
   input wire logic                  srst,     // Reset
   input wire tsg_pkg::tsg_apb_req_t apb_req,  // APB request
   input wire tsg_pkg::tsg_apb_rsp_t apb_rsp,  // APB answer
   input wire logic                  tx_data,  // Bit stream
   input wire logic                  tx_active // Symbol live
);
   import tsg_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [15:0] run;
   logic        acc;
   logic        rdac;
   // ******************
   // Helpers
   // ******************
   assign acc = apb_req.psel && apb_req.penable;
   assign rdac = acc && !apb_req.pwrite;
   // Length of the current live run
   always_ff @(posedge ref_clk)
   begin
      if (srst || !tx_active) run <= 16'h0000;
      else run <= run + 16'h0001;
   end
   // ******************
   // Assertions
   // ******************
   chk_ready_high: assert property (acc |-> apb_rsp.pready)
      else $error("pready low in access");
   chk_idle_rdata: assert property (!acc |-> apb_rsp.prdata == 32'h0)
      else $error("read data outside access");
   chk_upper_zero: assert property (rdac |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_misalign_err: assert property (acc && apb_req.paddr[1:0] != 2'h0
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("misaligned taken");
   chk_len_rsvd: assert property (rdac && apb_req.paddr == 12'h150
      |-> !apb_rsp.prdata[7] && !apb_rsp.prdata[3]) else $error("length spare set");
   chk_burst_rsvd: assert property (rdac && apb_req.paddr == 12'h154
      |-> !apb_rsp.prdata[7] && !apb_rsp.prdata[3]) else $error("burst spare set");
   chk_mod_rsvd: assert property (rdac && apb_req.paddr == 12'h158
      |-> !apb_rsp.prdata[7]) else $error("modulation spare set");
   chk_quiet_reset: assert property ($rose(tx_active)
      |-> !$past(srst) && !$past(srst, 2)) else $error("symbol right after reset");
   chk_run_whole: assert property ($fell(tx_active)
      |-> run != 16'h0 && run % BIT_CLKS == 0) else $error("partial bit time");
   cover property ($fell(tx_active));
   cover property (acc && apb_rsp.pslverr);
   cover property (acc && apb_req.pwrite && apb_req.paddr == 12'h188);
endmodule // tsg_props

bind tsg_symbol_gen tsg_props #(.BIT_CLKS(BIT_CLKS)) u_props (
   .ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .tx_data(tx_data), .tx_active(tx_active));

/* tsg_rf_model.sv */
// RF driver model: tallies live and high cycles of the stream.
// Assumes tx_data and tx_active are registered on ref_clk.
`timescale 1ns/1ns
module tsg_rf_model (
   input  wire logic ref_clk,   // Clock
   input  wire logic tx_data,   // Bit stream
   input  wire logic tx_active, // Symbol live
   output int        act_cnt,   // Live cycles
   output int        high_cnt   // Live high cycles
);
   // Counters only grow; the bench takes differences
   initial
   begin
      act_cnt = 0;
      high_cnt = 0;
      forever
      begin
         @(posedge ref_clk);
         if (tx_active === 1'b1) act_cnt <= act_cnt + 1;
         if (tx_active === 1'b1 && tx_data === 1'b1) high_cnt <= high_cnt + 1;
      end
   end
endmodule // tsg_rf_model

/* tb_top.sv */
// Self-checking bench of the transmit symbol generator.
// Assumes tsg_pkg, the design, checker and RF model are compiled.
`timescale 1ns/1ns
module tb_top;
   import tsg_pkg::*;
   localparam int B = 4;
   logic         ref_clk;
   logic         srst;
   tsg_apb_req_t req;
   tsg_apb_rsp_t rsp;
   logic         tx_data;
   logic         tx_active;
   logic [31:0]  rd;
   logic         err;
   int           act_cnt;
   int           high_cnt;
   int           n_mismatch;
   int           tests_run;

   tsg_symbol_gen #(.BIT_CLKS(B)) DUT (.ref_clk(ref_clk), .srst(srst), .apb_req(req),
      .apb_rsp(rsp), .tx_data(tx_data), .tx_active(tx_active));
   tsg_rf_model u_rf (.ref_clk(ref_clk), .tx_data(tx_data), .tx_active(tx_active),
      .act_cnt(act_cnt), .high_cnt(high_cnt));

   // ******************
   // Helpers
   // ******************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (rsp.pready === 1'b1) break;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'h0, i, 2'h0};
   endfunction
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, ad(i), d);
   endtask
   function automatic logic [7:0] msk(input logic [7:0] i);
      return (i == 8'h56) ? 8'h7F : (i == 8'h54 || i == 8'h55) ? 8'h77 : 8'hFF;
   endfunction
   function automatic int pop(input logic [15:0] p, input int n);
      int c = 0;
      for (int k = 0; k <= n; k++) c += p[k];
      return c;
   endfunction
   function automatic int env_high(input int e, input int n, input int pc);
      return (e == 0) ? pc * B : (e == 1) ? n * B / 2 : (e >= 6) ? 0 : pc * B / 2;
   endfunction
   // Miller: one quarter per 1, and per 0 not following a 1
   function automatic int mil(input logic [15:0] p, input int n);
      int c = 0;
      logic v = 1'b0;
      for (int k = n; k >= 0; k--)
      begin
         c += (p[k] || !v) ? B / 4 : 0;
         v = p[k];
      end
      return c;
   endfunction
   // Start a symbol, wait for idle, compare tallies
   task automatic send(input logic [1:0] s, input int ea, input int eh);
      int a0 = act_cnt;
      int h0 = high_cnt;
      int k = 0;
      wr(8'h62, {1'b1, 5'h00, s});
      do
      begin
         apb(1'b0, ad(8'h63), 8'h00);
         k++;
      end while (rd[0] !== 1'b0 && k < 500);
      repeat (8) @(posedge ref_clk);
      check("live cycles", act_cnt - a0, ea);
      check("high cycles", high_cnt - h0, eh);
   endtask

   // ******************
   // Clock and watchdog
   // ******************
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      finish_test();
   end

   // ******************
   // Main sequence
   // ******************
   initial
   begin
      logic [7:0]  i;
      logic [7:0]  l;
      logic [15:0] p;
      int          n0;
      int          n1;
      srst = 1'b1;
      req = '0;
      n_mismatch = 0;
      tests_run = 0;
      p = $urandom(32'h77FA59D0);
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      // Reset values, random read-back
      for (i = 8'h4D; i <= 8'h56; i++)
      begin
         apb(1'b0, ad(i), 8'h00);
         check("reset value", rd, 32'h0);
         p = $urandom;
         wr(i, p[7:0]);
         apb(1'b0, ad(i), 8'h00);
         check("read back", rd, {24'h0, p[7:0] & msk(i)});
      end
      // Refused transfers store nothing
      wr(8'h51, 8'h5A);
      apb(1'b1, ad(8'h51) | 12'h001, 8'hFF);
      check("misaligned", err, 1);
      apb(1'b0, ad(8'h70), 8'h00);
      check("unmapped", {rd[30:0], err}, 32'h1);
      apb(1'b0, ad(8'h51), 8'h00);
      check("no store", rd, 32'h5A);
      wr(8'h60, 8'h03);
      wr(8'h61, 8'hFF);
      apb(1'b0, ad(8'h61), 8'h00);
      check("rate bit", rd, 32'h8);
      for (int t = 0; t < 6; t++)
      begin
         p = $urandom;
         l = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : 8'($urandom);
         n0 = l[3:0];
         n1 = l[7:4];
         wr(8'h4D, p[15:8]);
         wr(8'h4E, p[7:0]);
         wr(8'h4F, p[15:8]);
         wr(8'h50, p[7:0]);
         wr(8'h51, p[7:0]);
         wr(8'h52, p[7:0]);
         wr(8'h53, l);
         wr(8'h54, l & 8'h77);
         wr(8'h55, 8'h00);
         for (int e = 0; e < 8; e++)
         begin
            if (e == 2 || e == 3) continue;
            wr(8'h56, 8'(e));
            send(2'd0, (n0 + 1) * B, env_high(e, n0 + 1, pop(p, n0)));
         end
         wr(8'h56, 8'h00);
         send(2'd2, (l[2:0] + 1) * B, pop(p, l[2:0]) * B);
         send(2'd3, (l[6:4] + 1) * B, pop(p, l[6:4]) * B);
         for (int k = 1; k < 4; k++)
         begin
            wr(8'h56, 8'(k << 4));
            send(2'd1, (n1 + 1) * B, pop(p, n1) * B / 4);
         end
         wr(8'h56, 8'h08);
         send(2'd1, (n1 + 1) * B, (n1 + 1 - pop(p, n1)) * B);
         wr(8'h56, 8'h50);
         send(2'd0, (n0 + 1) * B, mil(p, n0));
         wr(8'h56, 8'h00);
         wr(8'h55, t[0] ? 8'h07 : 8'h03);
         send(2'd0, 3 * B, t[0] ? 3 * B : 0);
         wr(8'h55, 8'h70);
         send(2'd1, 3 * B, 3 * B);
         wr(8'h55, 8'h10);
         send(2'd1, (n1 + 4) * B, pop(p, n1) * B);
      end
      finish_test();
   end
endmodule // tb_top
